// >>> rtl/sqs_consts.vh
// Purpose: constants for the serial flash side register block
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: included by sqs_side.v and by both bench files; the guard keeps one copy per file
`ifndef SQS_CONSTS_VH
`define SQS_CONSTS_VH
`define SQS_ADR_CTRL 32'h101c0d2c
`define SQS_ADR_IRQ_MASK 32'h101c0d14
`define SQS_ADR_IRQ_RAW 32'h101c0d18
`define SQS_ADR_IRQ_MASKED 32'h101c0d1c
`define SQS_ADR_IRQ_CLEAR 32'h101c0d20
`define SQS_ADR_IRQ_CPU_SEL 32'h101c0d24
`define SQS_ADR_DMA_CTRL 32'h101c0d28
`define SQS_ADR_PIN_OUT 32'h101c0d30
`define SQS_ADR_PIN_OE 32'h101c0d34
`define SQS_ADR_PIN_IN 32'h101c0d38
`define SQS_ADR_XIP_CFG 32'h101c0d3c
`define SQS_CPU_SEL_RST 2'h1
`define SQS_XIP_CFG_RST 32'h02020004
`define SQS_XIP_CFG_MASK 32'hff37ff7f
`define SQS_CFG_DIV_HI 31
`define SQS_CFG_DIV_LO 24
`define SQS_CFG_CSH_HI 21
`define SQS_CFG_CSH_LO 20
`define SQS_CFG_DUM_HI 18
`define SQS_CFG_DUM_LO 16
`define SQS_CFG_CMD_HI 15
`define SQS_CFG_CMD_LO 8
`define SQS_CFG_ABITS_HI 6
`define SQS_CFG_ABITS_LO 4
`define SQS_CFG_NIB_HI 3
`define SQS_CFG_NIB_LO 2
`define SQS_CFG_ADDR_FIRST 1
`define SQS_CFG_EN 0
`define SQS_CTRL_EN 0
`define SQS_CTRL_PIO 1
`define SQS_DIV_OFFSET 9'h003
`define SQS_ABITS_MAX 3'h4
`define SQS_BURST 5'h04
`define SQS_FIFO_DEPTH 5'h10
`define SQS_TIMEOUT_PERIODS 6'h20
`endif

// >>> rtl/sqs_side.v
// Purpose: side registers of a quad serial controller: irq, dma, pin control, xip reads
// Assumes: one 20 MHz clock; fifo level events come from the serial core on that clock
// Notes: pins are sampled through two flops; output enables are active low
`timescale 1ns/1ps
`include "sqs_consts.vh"
module sqs_side #(
  parameter RX_WM = 5'h08,
  parameter TX_WM = 5'h08
) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [31:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_rx_push,
  input wire i_rx_pop,
  input wire i_tx_push,
  input wire i_tx_pop,
  input wire i_trans_end,
  output reg o_rx_flush,
  output reg o_serial_block,
  output reg o_tx_dma_req,
  output reg o_tx_dma_burst,
  output reg o_rx_dma_req,
  output reg o_rx_dma_burst,
  output reg o_irq_main,
  output reg o_irq_aux,
  input wire i_xip_req,
  input wire [23:0] i_xip_addr,
  output reg [31:0] o_xip_data,
  output reg o_xip_ack,
  output reg o_xip_err,
  input wire [5:0] i_pin_in,
  output reg [5:0] o_pin_out,
  output reg [5:0] o_pin_oe_n
);
  // xip engine states, one-hot
  localparam ST_IDLE = 5'h01;
  localparam ST_SEND = 5'h02;
  localparam ST_DUMMY = 5'h04;
  localparam ST_READ = 5'h08;
  localparam ST_GAP = 5'h10;

  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  reg [1:0] ctrl_r;
  reg [8:0] mask_r;
  reg [8:0] raw_r;
  reg [1:0] cpu_sel_r;
  reg [1:0] dma_en_r;
  reg [5:0] pio_out_r;
  reg [5:0] pio_oe_r;
  reg [31:0] cfg_r;
  reg [4:0] rx_lvl_r;
  reg [4:0] tx_lvl_r;
  reg [9:0] per_cnt_r;
  reg [5:0] to_cnt_r;
  reg [4:0] st_r;
  reg [39:0] sh_r;
  reg [3:0] ncnt_r;
  reg [8:0] hcnt_r;
  reg sck_r;
  reg cs_n_r;
  reg dout_r;
  reg ph_r;
  reg [1:0] gap_r;
  reg [31:0] rd_r;

  // bus request and byte-lane write mask
  wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = req & i_wb_we;
  wire [31:0] bm = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wd = i_wb_dat & bm;
  wire wr_ctrl = wr & (i_wb_adr == `SQS_ADR_CTRL);
  wire wr_mask = wr & (i_wb_adr == `SQS_ADR_IRQ_MASK);
  wire wr_raw = wr & (i_wb_adr == `SQS_ADR_IRQ_RAW);
  wire wr_clr = wr & (i_wb_adr == `SQS_ADR_IRQ_CLEAR);
  wire wr_sel = wr & (i_wb_adr == `SQS_ADR_IRQ_CPU_SEL);
  wire wr_dma = wr & (i_wb_adr == `SQS_ADR_DMA_CTRL);
  wire wr_pout = wr & (i_wb_adr == `SQS_ADR_PIN_OUT);
  wire wr_poe = wr & (i_wb_adr == `SQS_ADR_PIN_OE);
  wire wr_cfg = wr & (i_wb_adr == `SQS_ADR_XIP_CFG);

  // register next values; reserved bits never stored
  wire [1:0] ctrl_nxt = wr_ctrl ? ((ctrl_r & ~bm[1:0]) | wd[1:0]) : ctrl_r;
  wire [1:0] dma_en_nxt = wr_dma ? ((dma_en_r & ~bm[1:0]) | wd[1:0]) : dma_en_r;
  wire [31:0] cfg_nxt = wr_cfg ? (((cfg_r & ~bm) | wd) & `SQS_XIP_CFG_MASK) : cfg_r;
  wire me_nxt = ctrl_nxt[`SQS_CTRL_EN];

  // config fields
  wire [7:0] div = cfg_r[`SQS_CFG_DIV_HI:`SQS_CFG_DIV_LO];
  wire [1:0] csh = cfg_r[`SQS_CFG_CSH_HI:`SQS_CFG_CSH_LO];
  wire [2:0] dum = cfg_r[`SQS_CFG_DUM_HI:`SQS_CFG_DUM_LO];
  wire [7:0] cmd = cfg_r[`SQS_CFG_CMD_HI:`SQS_CFG_CMD_LO];
  wire [2:0] abits = cfg_r[`SQS_CFG_ABITS_HI:`SQS_CFG_ABITS_LO];
  wire [1:0] nib = cfg_r[`SQS_CFG_NIB_HI:`SQS_CFG_NIB_LO];
  wire xip_en = cfg_r[`SQS_CFG_EN];
  wire [8:0] half = {1'b0, div} + `SQS_DIV_OFFSET;

  // fifo level tracking from core events
  wire rx_full = (rx_lvl_r == `SQS_FIFO_DEPTH);
  wire rx_ne = (rx_lvl_r != 5'h00);
  wire tx_full = (tx_lvl_r == `SQS_FIFO_DEPTH);
  wire flush = (wr_clr | wr_raw) & wd[0];
  wire rx_in = i_rx_push & ~rx_full;
  wire rx_out = i_rx_pop & rx_ne;
  wire tx_in = i_tx_push & ~tx_full;
  wire tx_out = i_tx_pop & (tx_lvl_r != 5'h00);

  // timeout period tick, free running at the serial clock rate
  wire per_tick = (per_cnt_r == ({half, 1'b0} - 10'h001));
  wire to_hit = per_tick & rx_ne & ~rx_out & (to_cnt_r == (`SQS_TIMEOUT_PERIODS - 6'h01));

  // sticky raw flags; a set in the same cycle as a clear wins
  wire [8:0] set_v;
  wire [8:0] clr_v = (wr_clr | wr_raw) ? wd[8:0] : 9'h000;
  wire [8:0] masked = raw_r & mask_r;
  assign set_v[0] = i_rx_push & rx_full;
  assign set_v[1] = to_hit;
  assign set_v[2] = (rx_lvl_r > RX_WM);
  assign set_v[3] = (tx_lvl_r < TX_WM);
  assign set_v[4] = rx_ne;
  assign set_v[5] = rx_full;
  assign set_v[6] = (tx_lvl_r == 5'h00);
  assign set_v[7] = i_trans_end;
  assign set_v[8] = o_xip_err;

  // address left-aligned, msb nibble first, masked to the selected width
  wire [4:0] nnib = {3'h0, nib} + 5'h05;
  wire [4:0] na = (abits > `SQS_ABITS_MAX) ? 5'h14 : (5'h14 + {2'h0, abits});
  wire [31:0] amask = ~(32'hffffffff << na);
  wire [31:0] a_left = ({8'h00, i_xip_addr} & amask) << (6'h20 - {nnib, 2'h0});
  wire [39:0] cmd_at = {32'h00000000, cmd} << (6'h20 - {nnib, 2'h0});
  wire [39:0] seq = cfg_r[`SQS_CFG_ADDR_FIRST] ? ({a_left, 8'h00} | cmd_at) : {cmd, a_left};
  // compare with >= so a divider lowered mid-gap cannot miss the edge and wrap
  wire hedge = (hcnt_r >= (half - 9'h001));

  // pin input synchroniser, and the registered bus slave
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ctrl_r <= 2'h0;
      mask_r <= 9'h000;
      cpu_sel_r <= `SQS_CPU_SEL_RST;
      dma_en_r <= 2'h0;
      pio_out_r <= 6'h00;
      pio_oe_r <= 6'h00;
      cfg_r <= `SQS_XIP_CFG_RST;
    end else if (i_ce) begin
      pin_s1_r <= i_pin_in;
      pin_s2_r <= pin_s1_r;
      o_wb_ack <= req;
      ctrl_r <= ctrl_nxt;
      dma_en_r <= dma_en_nxt;
      cfg_r <= cfg_nxt;
      if (wr_mask) begin
        mask_r <= (mask_r & ~bm[8:0]) | wd[8:0];
      end
      if (wr_sel) begin
        cpu_sel_r <= (cpu_sel_r & ~bm[1:0]) | wd[1:0];
      end
      if (wr_pout) begin
        pio_out_r <= (pio_out_r & ~bm[5:0]) | wd[5:0];
      end
      if (wr_poe) begin
        pio_oe_r <= (pio_oe_r & ~bm[5:0]) | wd[5:0];
      end
      if (req && !i_wb_we) begin
        case (i_wb_adr)
          `SQS_ADR_CTRL: o_wb_dat <= {30'h0, ctrl_r};
          `SQS_ADR_IRQ_MASK: o_wb_dat <= {23'h0, mask_r};
          `SQS_ADR_IRQ_RAW: o_wb_dat <= {23'h0, raw_r};
          `SQS_ADR_IRQ_MASKED: o_wb_dat <= {23'h0, masked};
          `SQS_ADR_IRQ_CLEAR: o_wb_dat <= 32'h00000000;
          `SQS_ADR_IRQ_CPU_SEL: o_wb_dat <= {30'h0, cpu_sel_r};
          `SQS_ADR_DMA_CTRL: o_wb_dat <= {30'h0, dma_en_r};
          `SQS_ADR_PIN_OUT: o_wb_dat <= {26'h0, pio_out_r};
          `SQS_ADR_PIN_OE: o_wb_dat <= {26'h0, pio_oe_r};
          `SQS_ADR_PIN_IN: o_wb_dat <= {26'h0, pin_s2_r};
          `SQS_ADR_XIP_CFG: o_wb_dat <= cfg_r;
          default: o_wb_dat <= 32'h00000000;
        endcase
      end else begin
        o_wb_dat <= 32'h00000000;
      end
    end
  end

  // fifo levels, flags, timeout, dma requests and interrupt lines
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_lvl_r <= 5'h00;
      tx_lvl_r <= 5'h00;
      raw_r <= 9'h000;
      per_cnt_r <= 10'h000;
      to_cnt_r <= 6'h00;
      o_rx_flush <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_tx_dma_burst <= 1'b0;
      o_rx_dma_req <= 1'b0;
      o_rx_dma_burst <= 1'b0;
      o_irq_main <= 1'b0;
      o_irq_aux <= 1'b0;
      o_serial_block <= 1'b0;
    end else if (i_ce) begin
      if (flush) begin
        rx_lvl_r <= 5'h00;
      end else begin
        rx_lvl_r <= rx_lvl_r + {4'h0, rx_in} - {4'h0, rx_out};
      end
      tx_lvl_r <= tx_lvl_r + {4'h0, tx_in} - {4'h0, tx_out};
      o_rx_flush <= flush;
      raw_r <= (raw_r & ~clr_v) | set_v;
      per_cnt_r <= per_tick ? 10'h000 : (per_cnt_r + 10'h001);
      // restart the unread count on any pop or when empty
      if (!rx_ne || rx_out || flush) begin
        to_cnt_r <= 6'h00;
      end else if (per_tick && to_cnt_r != `SQS_TIMEOUT_PERIODS) begin
        to_cnt_r <= to_cnt_r + 6'h01;
      end
      // enables taken from their next values so a clear drops the request at once
      o_tx_dma_req <= dma_en_nxt[1] & me_nxt & ~tx_full;
      o_tx_dma_burst <= dma_en_nxt[1] & me_nxt & ((`SQS_FIFO_DEPTH - tx_lvl_r) >= `SQS_BURST);
      o_rx_dma_req <= dma_en_nxt[0] & me_nxt & rx_ne;
      o_rx_dma_burst <= dma_en_nxt[0] & me_nxt & (rx_lvl_r >= `SQS_BURST);
      o_irq_main <= cpu_sel_r[0] & (|masked);
      o_irq_aux <= cpu_sel_r[1] & (|masked);
      o_serial_block <= xip_en;
    end
  end

  // xip read engine: command and address out, dummy cycles, eight data nibbles in
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
      sh_r <= 40'h0000000000;
      ncnt_r <= 4'h0;
      hcnt_r <= 9'h000;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      dout_r <= 1'b0;
      ph_r <= 1'b0;
      gap_r <= 2'h0;
      rd_r <= 32'h00000000;
      o_xip_data <= 32'h00000000;
      o_xip_ack <= 1'b0;
      o_xip_err <= 1'b0;
    end else if (i_ce) begin
      o_xip_ack <= 1'b0;
      o_xip_err <= 1'b0;
      if (st_r != ST_IDLE) begin
        hcnt_r <= hedge ? 9'h000 : (hcnt_r + 9'h001);
      end
      case (st_r)
        ST_IDLE: begin
          hcnt_r <= 9'h000;
          sck_r <= 1'b0;
          if (xip_en && i_xip_req && !o_xip_ack) begin
            if (abits > `SQS_ABITS_MAX) begin
              o_xip_err <= 1'b1; // reserved width refused
              o_xip_ack <= 1'b1;
              o_xip_data <= 32'h00000000;
            end else begin
              sh_r <= seq;
              ncnt_r <= nnib[3:0] + 4'h1;
              cs_n_r <= 1'b0;
              dout_r <= 1'b1;
              st_r <= ST_SEND;
            end
          end
        end
        ST_SEND, ST_DUMMY, ST_READ: begin
          if (hedge && !sck_r) begin
            sck_r <= 1'b1;
          end else if (hedge) begin
            sck_r <= 1'b0;
            // sampled at the fall: the pin path costs three cycles, within the six-cycle period at divider 0
            if (st_r == ST_READ) begin
              rd_r <= {rd_r[27:0], pin_s2_r[5:2]};
            end
            if (ncnt_r != 4'h0) begin
              ncnt_r <= ncnt_r - 4'h1;
              sh_r <= {sh_r[35:0], 4'h0};
            end else if (st_r == ST_SEND) begin
              dout_r <= 1'b0;
              st_r <= (dum == 3'h0) ? ST_READ : ST_DUMMY;
              ncnt_r <= (dum == 3'h0) ? 4'h7 : ({1'b0, dum} - 4'h1);
            end else if (st_r == ST_DUMMY) begin
              st_r <= ST_READ;
              ncnt_r <= 4'h7;
            end else begin
              cs_n_r <= 1'b1;
              o_xip_ack <= 1'b1;
              o_xip_data <= {rd_r[27:0], pin_s2_r[5:2]};
              gap_r <= csh;
              ph_r <= 1'b0;
              st_r <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // chip select high, clock held low, counted in whole periods
          if (hedge) begin
            ph_r <= ~ph_r;
            if (ph_r) begin
              if (gap_r == 2'h0) begin
                st_r <= ST_IDLE;
              end else begin
                gap_r <= gap_r - 2'h1;
              end
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // pin drive: xip first, then pin control, else released
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out <= 6'h00;
      o_pin_oe_n <= 6'h3f;
    end else if (i_ce) begin
      if (xip_en) begin
        o_pin_out <= {sh_r[39:36], cs_n_r, sck_r};
        o_pin_oe_n <= {{4{~dout_r}}, 2'h0};
      end else if (ctrl_r[`SQS_CTRL_EN] && ctrl_r[`SQS_CTRL_PIO]) begin
        o_pin_out <= pio_out_r;
        o_pin_oe_n <= ~pio_oe_r;
      end else begin
        o_pin_out <= 6'h00;
        o_pin_oe_n <= 6'h3f;
      end
    end
  end
endmodule // sqs_side

// >>> tb/sqs_side_monitor.sv
// Purpose: port checks for the side register block
// Assumes: i_ce held high by the bench
// Notes: gap figures use the shortest serial period, six cycles
`timescale 1ns/1ps
`include "sqs_consts.vh"
module sqs_side_monitor (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [31:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire o_rx_flush,
  input wire o_serial_block,
  input wire o_tx_dma_req,
  input wire o_tx_dma_burst,
  input wire o_rx_dma_req,
  input wire o_rx_dma_burst,
  input wire o_xip_ack,
  input wire o_xip_err,
  input wire [5:0] o_pin_out,
  input wire [5:0] o_pin_oe_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // ack still low marks the taking edge
  wire take_rd = i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we;
  wire take_wr = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
  chk_clear_reads_zero: assert property (take_rd && i_wb_adr == `SQS_ADR_IRQ_CLEAR
    |=> o_wb_ack && o_wb_dat == 32'h0) else $error("clear register read not zero");
  chk_flush_pulse: assert property (take_wr && i_wb_adr == `SQS_ADR_IRQ_CLEAR && i_wb_dat[0]
    |-> ##[1:2] o_rx_flush) else $error("no receive flush");
  chk_dma_drop: assert property (take_wr && i_wb_adr == `SQS_ADR_DMA_CTRL
    && i_wb_dat[1:0] == 2'h0 |=> !o_tx_dma_req && !o_rx_dma_req) else $error("dma request held");
  chk_tx_burst: assert property (o_tx_dma_burst |-> o_tx_dma_req) else $error("lone tx burst");
  chk_rx_burst: assert property (o_rx_dma_burst |-> o_rx_dma_req) else $error("lone rx burst");
  chk_cs_gap: assert property (o_xip_ack && !o_xip_err |=> o_pin_out[1] [*6])
    else $error("select idle too short");
  chk_sck_still: assert property (o_serial_block && $past(o_serial_block) && o_pin_out[1]
    && $past(o_pin_out[1]) |-> $stable(o_pin_out[0])) else $error("clock moved while idle");
  chk_xip_drive: assert property (o_serial_block && $past(o_serial_block, 2)
    |-> o_pin_oe_n[1:0] == 2'h0) else $error("clock or select released");
  chk_err_clean: assert property (o_xip_err |-> o_xip_ack && o_pin_out[1])
    else $error("refused read not clean");
  chk_reserved_zero: assert property (take_rd && i_wb_adr inside {`SQS_ADR_PIN_OUT,
    `SQS_ADR_PIN_OE, `SQS_ADR_PIN_IN} |=> o_wb_dat[31:6] == 26'h0) else $error("reserved bits set");
endmodule // sqs_side_monitor
bind sqs_side sqs_side_monitor u_mon (.i_sys_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_rx_flush, .o_serial_block,
  .o_tx_dma_req, .o_tx_dma_burst, .o_rx_dma_req, .o_rx_dma_burst, .o_xip_ack, .o_xip_err,
  .o_pin_out, .o_pin_oe_n);

// >>> tb/sqs_flash_model.sv
// Purpose: behavioural quad flash answering xip reads
// Assumes: flash already in 4-bit command mode, select on chip select 0
// Notes: header nibbles pile up in o_hdr; the bench compares the low part
`timescale 1ns/1ps
module sqs_flash_model #(
  parameter logic [31:0] WORD = 32'hc35a96e1
) (
  input wire i_sck,
  input wire i_cs_n,
  input wire [3:0] i_dq,
  input wire [4:0] i_hdr_n,
  input wire [4:0] i_lead,
  output logic [3:0] o_dq = 4'h0,
  output logic o_dq_en = 1'b0,
  output logic [63:0] o_hdr = 64'h0
);
  int cnt = 0;
  // header nibbles are taken on rising edges while selected
  always @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt <= 0;
    end else begin
      if (cnt < i_hdr_n) o_hdr <= {o_hdr[59:0], i_dq};
      cnt <= cnt + 1;
    end
  end
  // read nibbles change on falls after the dummy cycles, lines released after
  always @(negedge i_sck or posedge i_cs_n) begin
    o_dq_en <= !i_cs_n && cnt >= i_lead && cnt < i_lead + 8;
    o_dq <= WORD[31 - 4 * ((cnt - i_lead) & 7) -: 4];
  end
endmodule // sqs_flash_model

// >>> tb/sqs_side_tb.sv
// Purpose: bench for the side register block
// Assumes: 20 MHz clock; i_ce held high
// Notes: fixed stimulus; expectations follow the register map
`timescale 1ns/1ps
`include "sqs_consts.vh"
module sqs_side_tb;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, xreq = 0, sk = 0;
  logic [31:0] adr = 0, dat = 0, q;
  logic [23:0] xadr = 0;
  logic [5:0] ext = 6'h15;
  logic [4:0] hn = 0, ld = 0;
  logic [2:0] ev = 0;
  int err_total = 0, cmp_count = 0, n, t0, tp;
  wire [31:0] rdat, xdat;
  wire [63:0] hdr;
  wire [5:0] pout, poe_n, pins;
  wire [3:0] fdq;
  wire blk, tq, tb, rq, rb, im, ia, xack, xerr, fen, ack;
  // released lines follow the flash data while it drives, else the bench level, which toggles in xip mode
  assign pins = (~poe_n & pout) | (poe_n & (fen ? {fdq, ext[1:0]} : ext));
  sqs_side u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_rx_push(ev[0]), .i_rx_pop(ev[1]), .i_tx_push(ev[2]), .i_tx_pop(1'b0),
    .i_trans_end(1'b0), .o_rx_flush(), .o_serial_block(blk), .o_tx_dma_req(tq),
    .o_tx_dma_burst(tb), .o_rx_dma_req(rq), .o_rx_dma_burst(rb), .o_irq_main(im),
    .o_irq_aux(ia), .i_xip_req(xreq), .i_xip_addr(xadr), .o_xip_data(xdat), .o_xip_ack(xack),
    .o_xip_err(xerr), .i_pin_in(pins), .o_pin_out(pout), .o_pin_oe_n(poe_n));
  sqs_flash_model u_flash (.i_sck(pins[0]), .i_cs_n(pins[1]), .i_dq(pins[5:2]), .i_hdr_n(hn),
    .i_lead(ld), .o_dq(fdq), .o_dq_en(fen), .o_hdr(hdr));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (blk === 1'b1) ext <= ~ext;
  task automatic conclude();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    repeat (20) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      err_total++;
      conclude();
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse(input logic [2:0] e, input int k);
    @(posedge clk);
    ev <= e;
    repeat (k) @(posedge clk);
    ev <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  // one xip read; measures the serial period between the first two rises
  task automatic execute_in_place(input logic [23:0] a, input logic [63:0] h, input int nb, input int per,
    input logic e);
    @(posedge clk);
    xreq <= 1;
    xadr <= a;
    n = 0;
    t0 = 0;
    tp = 0;
    repeat (1000) begin
      @(posedge clk);
      n++;
      if (pins[0] && !sk && t0 == 0) t0 = n;
      else if (pins[0] && !sk && tp == 0) tp = n - t0;
      sk = pins[0];
      if (xack === 1'b1) break;
    end
    xreq <= 0;
    if (xack !== 1'b1) begin
      err_total++;
      conclude();
    end
    chk(xerr, e);
    if (!e) begin
      chk(xdat, 32'hc35a96e1);
      chk(hdr & ((64'h1 << (4 * nb)) - 64'h1), h);
      chk(tp, per);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    rd(`SQS_ADR_IRQ_CPU_SEL, 32'h1);
    rd(`SQS_ADR_XIP_CFG, 32'h02020004);
    rd(`SQS_ADR_DMA_CTRL, 32'h0);
    rd(32'h101c0d40, 32'h0);
    wr(`SQS_ADR_IRQ_CLEAR, 32'hffffffff);
    rd(`SQS_ADR_IRQ_CLEAR, 32'h0);
    // overrun routed to the main processor, then to the aux one
    wr(`SQS_ADR_IRQ_MASK, 32'h11);
    pulse(3'h1, 17);
    rd(`SQS_ADR_IRQ_MASKED, 32'h11);
    chk({im, ia}, 2'h2);
    wr(`SQS_ADR_IRQ_CPU_SEL, 32'h2);
    repeat (2) @(posedge clk);
    chk({im, ia}, 2'h1);
    wr(`SQS_ADR_IRQ_CLEAR, 32'h1ff);
    // level bits still true at the flushing edge win over the clear
    rd(`SQS_ADR_IRQ_RAW, 32'h7c);
    wr(`SQS_ADR_IRQ_CLEAR, 32'h1ff);
    rd(`SQS_ADR_IRQ_RAW, 32'h48);
    // receive timeout is 32 periods of 10 cycles
    pulse(3'h1, 1);
    repeat (290) @(posedge clk);
    rd(`SQS_ADR_IRQ_RAW, 32'h58);
    repeat (60) @(posedge clk);
    rd(`SQS_ADR_IRQ_RAW, 32'h5a);
    wr(`SQS_ADR_IRQ_CLEAR, 32'h1);
    // dma requests and bursts, order tq tb rq rb
    wr(`SQS_ADR_CTRL, 32'h1);
    wr(`SQS_ADR_DMA_CTRL, 32'h3);
    pulse(3'h1, 4);
    chk({tq, tb, rq, rb}, 4'hf);
    pulse(3'h2, 1);
    chk({tq, tb, rq, rb}, 4'he);
    wr(`SQS_ADR_DMA_CTRL, 32'h1);
    chk({tq, tb, rq, rb}, 4'h2);
    wr(`SQS_ADR_DMA_CTRL, 32'h3);
    pulse(3'h4, 13);
    chk({tq, tb, rq, rb}, 4'ha);
    pulse(3'h4, 3);
    chk({tq, tb, rq, rb}, 4'h2);
    wr(`SQS_ADR_CTRL, 32'h0);
    chk({tq, tb, rq, rb}, 4'h0);
    wr(`SQS_ADR_DMA_CTRL, 32'h0);
    // pin control
    wr(`SQS_ADR_CTRL, 32'h3);
    wr(`SQS_ADR_PIN_OUT, 32'hffffffea);
    wr(`SQS_ADR_PIN_OE, 32'h3f);
    repeat (2) @(posedge clk);
    chk({pout, poe_n}, 12'ha80);
    rd(`SQS_ADR_PIN_OUT, 32'h2a);
    wr(`SQS_ADR_PIN_OE, 32'h5);
    repeat (4) @(posedge clk);
    chk(poe_n, 6'h3a);
    rd(`SQS_ADR_PIN_IN, 32'h10);
    wr(`SQS_ADR_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk(poe_n, 6'h3f);
    wr(`SQS_ADR_CTRL, 32'h0);
    // xip: command first, then address first with 8 nibbles, then reserved width
    hn <= 5'h08;
    ld <= 5'h0b;
    wr(`SQS_ADR_XIP_CFG, 32'h0113eb45);
    repeat (2) @(posedge clk);
    chk(blk, 1'b1);
    execute_in_place(24'h9abcde, 64'heb9abcde, 8, 8, 1'b0);
    hn <= 5'h0a;
    ld <= 5'h0a;
    wr(`SQS_ADR_XIP_CFG, 32'h00006c2f);
    execute_in_place(24'hffffff, 64'h003fffff6c, 10, 6, 1'b0);
    wr(`SQS_ADR_XIP_CFG, 32'h00006c5d);
    execute_in_place(24'h0, 64'h0, 0, 0, 1'b1);
    wr(`SQS_ADR_XIP_CFG, 32'h0);
    repeat (2) @(posedge clk);
    chk(blk, 1'b0);
    conclude();
  end
endmodule // sqs_side_tb
